// file: fdsp_consts.svh
// Constants for the floppy data separator and precompensation block
`ifndef FDSP_CONSTS_SVH
`define FDSP_CONSTS_SVH
// Read clock half periods for divide-by-16 and divide-by-8
`define FDSP_HALF_DIV16 4'h8
`define FDSP_HALF_DIV8 4'h4
// Early and late zone width at each end of a half period
`define FDSP_EDGE_DIV16 4'h3
`define FDSP_EDGE_DIV8 4'h1
`define FDSP_CNT_W 4
`define FDSP_SEL_NOMINAL 2'h1
`define FDSP_SEL_EARLY 2'h0
`define FDSP_SEL_LATE 2'h2
// Pin positions in the synchroniser bank
`define FDSP_PIN_DD 4'hB
`define FDSP_PIN_READ 4'hA
`define FDSP_PIN_FAULT 4'h9
`define FDSP_PIN_GATE 4'h8
`define FDSP_PIN_WR 4'h7
`define FDSP_PIN_EARLY 4'h6
`define FDSP_PIN_LATE 4'h5
`define FDSP_PIN_INNER 4'h4
`define FDSP_PIN_PH_HI 4'h3
`define FDSP_PIN_PH_LO 4'h0
`endif

// file: fdsp_pkg.sv
// Types for the floppy data separator and precompensation block
package fdsp_pkg;
    typedef enum logic [1:0] {
        FDSP_PUMP_IDLE = 2'b00,
        FDSP_PUMP_UP = 2'b01,
        FDSP_PUMP_DOWN = 2'b10
    } fdsp_pump_t;
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
    } fdsp_sync_t;
    typedef struct packed {
        logic [3:0] div;
        logic rclk;
        logic rd_prev;
        fdsp_pump_t pump;
        logic up;
        logic dn;
        logic up_oe_n;
        logic dn_oe_n;
        logic wr_prev;
        logic strobe;
        logic [1:0] sel;
        logic ph4_prev;
        logic wout;
    } fdsp_state_t;
endpackage : fdsp_pkg

// file: fdsp_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module fdsp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    always_ff @(posedge clk_i) begin
        s1_q <= d_i;
        s2_q <= s1_q;
    end
    assign q_o = s2_q;
endmodule : fdsp_sync2
`default_nettype wire

// file: fdsp_top.sv
// Floppy read data separator and write precompensation logic
//
// Contract
// - Write gate high disables recovery, pumps float
// - Recovery enabled only when gate and enable low
// - Pumps act only while read pulse low
// - Early read edge drives pump-up high
// - Late read edge drives pump-down low
// - Centred read edge leaves both pumps floating
// - Read clock divides oscillator by 16 or 8
// - Read clock high in data half
// - Pump lasts as long as read pulse
// - Early/late pick phase at write edge
// - Write edge sets strobe high
// - Nominal uses phase two, late phase three
// - Phase four leading edge clears strobe
// - Bypass when inner track low or single density
// - Select and read inputs default high
`timescale 1ns/1ps
`default_nettype none
`include "fdsp_consts.svh"
module fdsp_top
    import fdsp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic double_density_select_n_i,
    input wire logic raw_read_pulse_n_i,
    input wire logic read_enable_write_fault_i,
    input wire logic write_gate_in_i,
    input wire logic write_pulse_in_i,
    input wire logic early_i,
    input wire logic late_i,
    input wire logic inner_track_select_i,
    input wire logic [3:0] phase_i,
    output logic read_clock_o,
    output logic pump_up_out_o,
    output logic pump_up_out_oe_n_o,
    output logic pump_down_out_o,
    output logic pump_down_out_oe_n_o,
    output logic phase_start_strobe_o,
    output logic write_pulse_out_o
);
    // Pins are asynchronous to the core clock; the oscillator input is
    // modelled as core_clk_i itself, so one clock domain remains.
    logic [11:0] pins_raw;
    logic [11:0] pins;
    fdsp_state_t st_q;
    fdsp_state_t st_d;

    // Undriven select and read pins are pulled high at the pad; the core sees a one.
    // Order follows the pin positions of the synchroniser bank.
    assign pins_raw = {
        double_density_select_n_i,
        raw_read_pulse_n_i,
        read_enable_write_fault_i,
        write_gate_in_i,
        write_pulse_in_i,
        early_i,
        late_i,
        inner_track_select_i,
        phase_i
    };

    // One bank for all pins keeps gate and fault aligned with each other
    fdsp_sync2 #(.W(12)) u_sync (
        .clk_i(core_clk_i),
        .d_i(pins_raw),
        .q_o(pins)
    );

    logic dd_sel_n;
    logic rd_pulse_n;
    logic rd_off_fault;
    logic wr_gate;
    logic wr_pulse;
    logic early;
    logic late;
    logic inner_trk;
    logic [3:0] ph;

    assign dd_sel_n = pins[`FDSP_PIN_DD];
    assign rd_pulse_n = pins[`FDSP_PIN_READ];
    assign rd_off_fault = pins[`FDSP_PIN_FAULT];
    assign wr_gate = pins[`FDSP_PIN_GATE];
    assign wr_pulse = pins[`FDSP_PIN_WR];
    assign early = pins[`FDSP_PIN_EARLY];
    assign late = pins[`FDSP_PIN_LATE];
    assign inner_trk = pins[`FDSP_PIN_INNER];
    assign ph = pins[`FDSP_PIN_PH_HI:`FDSP_PIN_PH_LO];

    // Decode of the synchronised pins
    logic rec_en;
    logic precomp_on;
    logic [1:0] pick;
    logic [3:0] half;
    logic [3:0] edge_w;
    logic div_last;
    logic rd_fall;
    logic in_early;
    logic in_late;
    logic wr_rise;
    logic ph4_rise;

    assign rec_en = !wr_gate && !rd_off_fault;
    // Single density or outer tracks pass write data straight through
    assign precomp_on = !dd_sel_n && inner_trk;
    assign pick = {early, late};

    always_comb begin
        st_d = st_q;
        // Divider; >= also ends a half cut short by a density change
        half = dd_sel_n ? `FDSP_HALF_DIV16 : `FDSP_HALF_DIV8;
        edge_w = dd_sel_n ? `FDSP_EDGE_DIV16 : `FDSP_EDGE_DIV8;
        div_last = st_q.div >= half - 4'h1;
        if (div_last) begin
            st_d.div = 4'h0;
            st_d.rclk = !st_q.rclk;
        end else begin
            st_d.div = st_q.div + 4'h1;
        end

        // Window position of a falling read edge picks the correction
        // Centre lies between the two zones and needs no correction
        st_d.rd_prev = rd_pulse_n;
        rd_fall = st_q.rd_prev && !rd_pulse_n;
        in_early = st_q.div < edge_w;
        in_late = st_q.div >= half - edge_w;
        case (st_q.pump)
            FDSP_PUMP_IDLE: begin
                if (rd_fall && in_early) begin
                    st_d.pump = FDSP_PUMP_UP;
                end else if (rd_fall && in_late) begin
                    st_d.pump = FDSP_PUMP_DOWN;
                end else begin
                    st_d.pump = FDSP_PUMP_IDLE;
                end
            end
            FDSP_PUMP_UP, FDSP_PUMP_DOWN: begin
                // Correction lasts as long as the read pulse
                if (rd_pulse_n) begin
                    st_d.pump = FDSP_PUMP_IDLE;
                end
            end
            default: begin
                st_d.pump = FDSP_PUMP_IDLE;
            end
        endcase
        if (!rec_en) begin
            st_d.pump = FDSP_PUMP_IDLE;
        end

        // Only one enable at a time, so tied pumps never fight
        st_d.up = 1'b1;
        st_d.dn = 1'b0;
        st_d.up_oe_n = !(st_d.pump == FDSP_PUMP_UP);
        st_d.dn_oe_n = !(st_d.pump == FDSP_PUMP_DOWN);

        // Set after clear: a write edge in the phase-four cycle wins
        st_d.wr_prev = wr_pulse;
        st_d.ph4_prev = ph[3];
        wr_rise = !st_q.wr_prev && wr_pulse;
        ph4_rise = !st_q.ph4_prev && ph[3];
        if (ph4_rise) begin
            st_d.strobe = 1'b0;
        end
        if (precomp_on && wr_rise) begin
            st_d.strobe = 1'b1;
            // Early wins when both are asked for
            case (pick)
                2'h2, 2'h3: begin
                    st_d.sel = `FDSP_SEL_EARLY;
                end
                2'h1: begin
                    st_d.sel = `FDSP_SEL_LATE;
                end
                default: begin
                    st_d.sel = `FDSP_SEL_NOMINAL;
                end
            endcase
        end

        // Chosen phase passes one cycle after its sync
        if (precomp_on) begin
            st_d.wout = ph[st_q.sel];
        end else begin
            st_d.wout = wr_pulse;
        end

        // Reset floats both pumps and drops the strobe
        if (srst_i) begin
            st_d.div = 4'h0;
            st_d.rclk = 1'b0;
            st_d.rd_prev = 1'b0;
            st_d.pump = FDSP_PUMP_IDLE;
            st_d.up = 1'b0;
            st_d.dn = 1'b0;
            st_d.up_oe_n = 1'b1;
            st_d.dn_oe_n = 1'b1;
            st_d.wr_prev = 1'b0;
            st_d.strobe = 1'b0;
            st_d.sel = `FDSP_SEL_NOMINAL;
            st_d.ph4_prev = 1'b0;
            st_d.wout = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_q <= st_d;
    end

    // Pad values are fixed except that reset loads the up pad low; the enables alone carry the correction
    assign read_clock_o = st_q.rclk;
    assign pump_up_out_o = st_q.up;
    assign pump_up_out_oe_n_o = st_q.up_oe_n;
    assign pump_down_out_o = st_q.dn;
    assign pump_down_out_oe_n_o = st_q.dn_oe_n;
    assign phase_start_strobe_o = st_q.strobe;
    assign write_pulse_out_o = st_q.wout;
endmodule : fdsp_top
`default_nettype wire

// file: fdsp_top_properties.sv
// Port checks for the floppy separator and precomp block
`timescale 1ns/1ps
`default_nettype none
module fdsp_checker (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic write_gate_in_i,
    input wire logic read_enable_write_fault_i,
    input wire logic raw_read_pulse_n_i,
    input wire logic read_clock_o,
    input wire logic pump_up_out_o,
    input wire logic pump_up_out_oe_n_o,
    input wire logic pump_down_out_o,
    input wire logic pump_down_out_oe_n_o,
    input wire logic phase_start_strobe_o
);
    // Three samples cover the two sync flops plus the state flop
    wire logic off = pump_up_out_oe_n_o & pump_down_out_oe_n_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    gate_float_a: assert property (write_gate_in_i[*3] |=> off)
        else $error("pump on in write");
    fault_float_a: assert property (
        read_enable_write_fault_i[*3] |=> off) else $error("pump on in fault");
    idle_float_a: assert property (raw_read_pulse_n_i[*3] |=> off)
        else $error("pump on while idle");
    pump_excl_a: assert property (
        pump_up_out_oe_n_o | pump_down_out_oe_n_o) else $error("both pumps");
    up_level_a: assert property (
        !pump_up_out_oe_n_o |-> pump_up_out_o) else $error("up level");
    down_level_a: assert property (
        !pump_down_out_oe_n_o |-> !pump_down_out_o) else $error("down level");
    clock_toggle_a: assert property (
        $rose(read_clock_o) |-> ##[1:8] $fell(read_clock_o))
        else $error("read clock stuck");
    reset_quiet_a: assert property (
        $fell(srst_i) |-> off && !phase_start_strobe_o) else $error("reset");
endmodule : fdsp_checker
bind fdsp_top fdsp_checker u_chk (.*);
`default_nettype wire

// file: fdsp_phase_gen.sv
// Four-phase pulse generator model started by the strobe
`timescale 1ns/1ps
`default_nettype none
module fdsp_phase_gen (
    input wire logic clk_i,
    input wire logic strobe_i,
    output logic [3:0] phase_o
);
    logic [3:0] cnt_q = 4'h0;
    logic strobe_q = 1'b0;
    // Two cycles a phase so each pulse outlives the input sync
    assign phase_o = cnt_q[3] ? 4'h1 << cnt_q[2:1] : 4'h0;
    always_ff @(posedge clk_i) begin
        strobe_q <= strobe_i;
        if (strobe_i && !strobe_q)
            cnt_q <= 4'h8;
        else if (cnt_q[3])
            cnt_q <= cnt_q + 4'h1;
    end
endmodule : fdsp_phase_gen
`default_nettype wire

// file: floppy_data_separator_precomp_test.sv
// Self-checking bench for the separator and precomp block
`timescale 1ns/1ps
`default_nettype none
module floppy_data_separator_precomp_test;
    logic core_clk_i = 1'b0, srst_i = 1'b1, double_density_select_n_i = 1'b1;
    logic raw_read_pulse_n_i = 1'b1, read_enable_write_fault_i = 1'b0;
    logic write_gate_in_i = 1'b0, write_pulse_in_i = 1'b0, early_i = 1'b0;
    logic late_i = 1'b0, inner_track_select_i = 1'b1, read_clock_o;
    logic pump_up_out_o, pump_up_out_oe_n_o, pump_down_out_o;
    logic pump_down_out_oe_n_o, phase_start_strobe_o, write_pulse_out_o;
    logic [3:0] phase_i;
    int miscompares = 0, n_tests = 0, d[3];
    always #2.5 core_clk_i = ~core_clk_i;
    fdsp_top dut (.*);
    fdsp_phase_gen gen (.clk_i(core_clk_i), .strobe_i(phase_start_strobe_o),
        .phase_o(phase_i));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc
    task automatic cmp(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic t_gate();
        raw_read_pulse_n_i <= 1'b0;
        write_gate_in_i <= 1'b1;
        cyc(5);
        cmp(pump_up_out_oe_n_o & pump_down_out_oe_n_o, 1'b1);
        write_gate_in_i <= 1'b0;
        read_enable_write_fault_i <= 1'b1;
        cyc(5);
        cmp(pump_up_out_oe_n_o & pump_down_out_oe_n_o, 1'b1);
        read_enable_write_fault_i <= 1'b0;
        raw_read_pulse_n_i <= 1'b1;
        $display("gate done");
    endtask : t_gate
    task automatic t_pump(input int off, input logic up, input logic dn);
        @(posedge read_clock_o);
        cyc(off);
        raw_read_pulse_n_i <= 1'b0;
        cyc(6);
        cmp(pump_up_out_oe_n_o, !up);
        cmp(pump_down_out_oe_n_o, !dn);
        raw_read_pulse_n_i <= 1'b1;
        cyc(4);
        cmp(pump_up_out_oe_n_o & pump_down_out_oe_n_o, 1'b1);
        $display("pump done");
    endtask : t_pump
    task automatic t_rclk(input logic sel, input int half);
        int n = 0;
        double_density_select_n_i <= sel;
        cyc(40);
        @(posedge read_clock_o);
        do begin
            cyc(1);
            n++;
        end while (read_clock_o === 1'b1);
        cmp(n == half + 1, 1'b1);
        $display("read clock done");
    endtask : t_rclk
    task automatic t_wr(input logic e, input logic l, input int i);
        int n = 0;
        early_i <= e;
        late_i <= l;
        cyc(4);
        write_pulse_in_i <= 1'b1;
        cyc(2);
        write_pulse_in_i <= 1'b0;
        cyc(3);
        cmp(phase_start_strobe_o, 1'b1);
        while (write_pulse_out_o !== 1'b1 && n < 30) begin
            cyc(1);
            n++;
        end
        d[i] = n;
        cyc(20);
        cmp(phase_start_strobe_o, 1'b0);
        $display("write done");
    endtask : t_wr
    task automatic t_byp();
        inner_track_select_i <= 1'b0;
        cyc(4);
        write_pulse_in_i <= 1'b1;
        cyc(4);
        cmp(write_pulse_out_o, 1'b1);
        write_pulse_in_i <= 1'b0;
        cyc(4);
        cmp(write_pulse_out_o, 1'b0);
        $display("bypass done");
    endtask : t_byp
    initial begin
        cyc(3);
        srst_i <= 1'b0;
        t_gate();
        t_pump(6, 1'b1, 1'b0);
        t_pump(2, 1'b0, 1'b0);
        t_pump(3, 1'b0, 1'b1);
        t_rclk(1'b1, 8);
        t_rclk(1'b0, 4);
        t_wr(1'b1, 1'b0, 0);
        t_wr(1'b0, 1'b0, 1);
        t_wr(1'b0, 1'b1, 2);
        cmp(d[1] - d[0] == 2, 1'b1);
        cmp(d[2] - d[1] == 2, 1'b1);
        t_byp();
        print_verdict();
    end
    initial begin
        cyc(3000);
        miscompares++;
        print_verdict();
    end
endmodule : floppy_data_separator_precomp_test
`default_nettype wire
